// ---- flash_host_pkg.sv ----
// constants, codes and carriers shared by the flash host controller files
// assumes a 20 MHz system clock and a byte-wide asynchronous parallel flash
package flash_host_pkg;
  // ****************************************************************
  // widths and clock
  // ****************************************************************
  localparam int ADDR_W   = 21;          // top_address_line is line 20
  localparam int CLK_NS   = 50;          // clk_sys period
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int WE_LOW_NS   = 100;      // write strobe low time, least
  localparam int ACC_NS      = 100;      // read access time, least
  localparam int PROG_MAX_US = 20;       // byte program finishes within this
  localparam int WE_LOW_CYC  = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC     = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC    = 2;        // byte_bus input synchroniser depth
  localparam int PROG_LIMIT_CYC = PROG_MAX_US * 1000 / CLK_NS;
  localparam int STABLE_READS   = 2;     // agreeing re-reads before done
  // ****************************************************************
  // software register map
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // write: op code starts command
  localparam logic [7:0] OFS_ADDR   = 8'h04;  // target flash address
  localparam logic [7:0] OFS_DATA   = 8'h08;  // program byte
  localparam logic [7:0] OFS_STATUS = 8'h0C;  // busy, done, timeout, read byte
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TOUT = 2;
  localparam int ST_BYTE = 8;                 // read byte at bits 15:8
  // ****************************************************************
  // operation codes and flash command bytes
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_SECTOR, OP_BLOCK, OP_CHIP, OP_IDENT, OP_QUERY, OP_LEAVE
  } op_t;
  localparam logic [14:0] UNLOCK_A1 = 15'h5555;
  localparam logic [14:0] UNLOCK_A2 = 15'h2AAA;
  localparam logic [7:0]  UNLOCK_D1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_D2 = 8'h55;
  localparam logic [7:0]  CMD_PROG  = 8'hA0;
  localparam logic [7:0]  CMD_ERASE = 8'h80;
  localparam logic [7:0]  CMD_IDENT = 8'h90;
  localparam logic [7:0]  CMD_QUERY = 8'h98;
  localparam logic [7:0]  CMD_LEAVE = 8'hF0;
  localparam logic [7:0]  CMD_SECT  = 8'h30;
  localparam logic [7:0]  CMD_BLOCK = 8'h50;
  localparam logic [7:0]  CMD_CHIP  = 8'h10;
  localparam int          BUSY_BIT  = 6;       // alternating_busy_bit
  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic              wr;    // 1 write cycle, 0 read cycle
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } bus_req_t;
  typedef struct packed {
    logic              last;  // final write of the sequence
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } seq_word_t;
endpackage : flash_host_pkg

// ---- flash_bus_cycle.sv ----
// one asynchronous flash bus cycle, write or read, on the flash pins
// assumes the caller pulses start only while done is low and no cycle runs
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input  wire logic                   clk_sys,      // system clock
  input  wire logic                   sys_rst,      // async reset, high
  input  wire logic                   start,        // one-cycle request
  input  wire flash_host_pkg::bus_req_t req,        // cycle kind, address, data
  output logic                        done,         // one-cycle completion
  output logic [7:0]                  rd_byte,      // byte read
  output logic [ADDR_W-1:0]           flash_addr,   // address pins
  output logic                        ce_n,         // chip select, low
  output logic                        oe_n,         // output gate, low
  output logic                        we_n,         // write strobe, low
  output logic [7:0]                  byte_bus_out, // data pins, driven value
  output logic                        byte_bus_oe,  // data pins, drive enable
  input  wire logic [7:0]             byte_bus_in   // data pins, sensed value
);
  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_READ} cyc_t;
  cyc_t              st_reg, st_next;
  logic [3:0]        cnt_reg, cnt_next;
  logic [7:0]        sync1_reg, sync2_reg;
  logic              done_next;
  logic [7:0]        rd_next, out_next;
  logic [ADDR_W-1:0] addr_next;
  logic              ce_next, oe_next, we_next, drv_next;

  // ****************************************************************
  // two-flop synchroniser for the data pins
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= byte_bus_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  // next pin levels; data driven only while the output gate is high
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    rd_next   = rd_byte;
    addr_next = flash_addr;
    out_next  = byte_bus_out;
    ce_next   = ce_n;
    oe_next   = oe_n;
    we_next   = we_n;
    drv_next  = byte_bus_oe;
    case (st_reg)
      C_IDLE: begin
        if (start) begin
          addr_next = req.addr;
          ce_next   = 1'b0;
          if (req.wr) begin
            out_next = req.data;
            drv_next = 1'b1;
            st_next  = C_SETUP;
          end else begin
            oe_next  = 1'b0;
            cnt_next = 4'(ACC_CYC + SYNC_CYC - 1);
            st_next  = C_READ;
          end
        end
      end
      C_SETUP: begin
        we_next  = 1'b0;                 // pulse far above the glitch floor
        cnt_next = 4'(WE_LOW_CYC - 1);
        st_next  = C_PULSE;
      end
      C_PULSE: begin
        if (cnt_reg == 4'h0) begin
          we_next = 1'b1;                // device latches data on this edge
          st_next = C_HOLD;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      C_HOLD: begin
        ce_next   = 1'b1;
        drv_next  = 1'b0;
        done_next = 1'b1;
        st_next   = C_IDLE;
      end
      C_READ: begin
        if (cnt_reg == 4'h0) begin
          rd_next   = sync2_reg;
          ce_next   = 1'b1;
          oe_next   = 1'b1;
          done_next = 1'b1;
          st_next   = C_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: st_next = C_IDLE;
    endcase
  end

  // register the pins and the cycle state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg       <= C_IDLE;
      cnt_reg      <= 4'h0;
      done         <= 1'b0;
      rd_byte      <= 8'h00;
      flash_addr   <= '0;
      byte_bus_out <= 8'h00;
      ce_n         <= 1'b1;
      oe_n         <= 1'b1;
      we_n         <= 1'b1;
      byte_bus_oe  <= 1'b0;
    end else begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      done         <= done_next;
      rd_byte      <= rd_next;
      flash_addr   <= addr_next;
      byte_bus_out <= out_next;
      ce_n         <= ce_next;
      oe_n         <= oe_next;
      we_n         <= we_next;
      byte_bus_oe  <= drv_next;
    end
  end
endmodule : flash_bus_cycle

// ---- flash_host_ctrl.sv ----
// host controller issuing command sequences to a parallel flash and polling completion
// assumes a plain register port master and the flash pins wired straight to the ports
//
// What the document says
// (RL1) device inverts top data bit while programming; true bit when done
// (RL2) device reads top bit zero while erasing, one after
// (RL3) program completion indications valid after the fourth write strobe
// (RL4) erase completion indications valid after the sixth write strobe
// (RL5) busy bit six alternates on each read during program or erase
// (RL6) bit six stops alternating at completion; next operation accepted
// (RL7) device ignores strobe pulses shorter than 5 ns
// (RL8) device blocks writes with output gate low or strobes high
// (RL9) every byte program is preceded by the three-write unlock prefix
// (RL10) every erase is started by the full six-write sequence
// (RL11) device keeps the software write guard always active
// (RL12) device abandons a broken sequence within one read cycle time
// (RL13) query entry is the unlock prefix ending with 98H at 5555H
// (RL14) query mode holds until the host writes the leave command
// (RL15) identification reads: 0000H maker code, 0001H part code
// (RL16) leave command returns device to array reads from any mode
// (RL17) device ignores the leave command during program or erase
// (RL18) device floats the data bus when output gate or select is high
// (RL19) device latches write data internally each write cycle
// (RL20) sector erase uses lines down to 12, block down to 16
// (RL21) sixth write 30H with sector address, 50H with block address
// (RL22) chip erase ends with 10H at 5555H, erasing all to one
// (RL23) device takes address on later fall, data on earlier rise
// (RL24) byte program finishes within 20 us; commands meanwhile ignored
// (RL25) host re-reads until completion indication settles before next command
//
// Our own choices: the register addresses and strobed register access.
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int ERASE_LIMIT_CYC = 2000000  // erase poll timeout in clocks
) (
  input  wire logic              clk_sys,      // system clock, 20 MHz
  input  wire logic              sys_rst,      // async reset, high
  input  wire logic [7:0]        reg_addr,     // register byte address
  input  wire logic [31:0]       reg_wdata,    // register write data
  input  wire logic              reg_wr,       // write strobe
  input  wire logic              reg_rd,       // read strobe
  output logic [31:0]            reg_rdata,    // read data, cycle after strobe
  output logic [ADDR_W-1:0]      flash_addr,   // flash address pins
  output logic                   ce_n,         // flash chip select
  output logic                   oe_n,         // flash output gate
  output logic                   we_n,         // flash write strobe
  output logic [7:0]             byte_bus_out, // flash data, driven value
  output logic                   byte_bus_oe,  // flash data, drive enable
  input  wire logic [7:0]        byte_bus_in   // flash data, sensed value
);
  typedef enum logic [2:0] {S_IDLE, S_WR, S_WR_WAIT, S_RD, S_RD_WAIT} st_t;
  st_t               st_reg, st_next;
  op_t               op_reg, op_next;
  logic [2:0]        step_reg, step_next;
  logic [ADDR_W-1:0] uaddr_reg, uaddr_next;
  logic [7:0]        udata_reg, udata_next;
  logic              busy_reg, busy_next, done_reg, done_next, tout_reg, tout_next;
  logic              poll_reg, poll_next, first_reg, first_next, prev_reg, prev_next;
  logic [1:0]        stable_reg, stable_next;
  logic [21:0]       timer_reg, timer_next;
  logic [7:0]        byte_reg, byte_next;
  logic              go_reg, go_next;
  bus_req_t          req_reg, req_next;
  logic [31:0]       rdata_next;
  logic              cyc_done;
  logic [7:0]        cyc_byte;
  seq_word_t         sw;
  logic [21:0]       limit;

  // ****************************************************************
  // command sequence table
  // ****************************************************************
  // word to write at a given step of an operation
  function automatic seq_word_t seq_word(input op_t op, input logic [2:0] step,
                                         input logic [ADDR_W-1:0] ua,
                                         input logic [7:0] ud);
    seq_word_t w;
    logic [7:0] cmd;
    w = '0;
    case (op)
      OP_PROG:  cmd = CMD_PROG;
      OP_IDENT: cmd = CMD_IDENT;
      OP_QUERY: cmd = CMD_QUERY;
      OP_LEAVE: cmd = CMD_LEAVE;
      default:  cmd = CMD_ERASE;
    endcase
    case (step)
      3'd0, 3'd3: w = '{1'b0, ADDR_W'(UNLOCK_A1), UNLOCK_D1};
      3'd1, 3'd4: w = '{1'b0, ADDR_W'(UNLOCK_A2), UNLOCK_D2};
      3'd2: w = '{(op == OP_IDENT) || (op == OP_QUERY) || (op == OP_LEAVE),
                  ADDR_W'(UNLOCK_A1), cmd};
      default: begin
        if (op == OP_SECTOR)     w = '{1'b1, ua, CMD_SECT};
        else if (op == OP_BLOCK) w = '{1'b1, ua, CMD_BLOCK};
        else                     w = '{1'b1, ADDR_W'(UNLOCK_A1), CMD_CHIP};
      end
    endcase
    if ((op == OP_PROG) && (step == 3'd3)) w = '{1'b1, ua, ud};
    return w;
  endfunction : seq_word

  assign sw    = seq_word(op_reg, step_reg, uaddr_reg, udata_reg);
  assign limit = (op_reg == OP_PROG) ? 22'(PROG_LIMIT_CYC) : 22'(ERASE_LIMIT_CYC);

  // ****************************************************************
  // operation sequencer and completion poll
  // ****************************************************************
  // next state, register writes and poll bookkeeping
  always_comb begin
    st_next = st_reg;  op_next = op_reg;  step_next = step_reg;
    uaddr_next = uaddr_reg;  udata_next = udata_reg;
    busy_next = busy_reg;  done_next = done_reg;  tout_next = tout_reg;
    poll_next = poll_reg;  first_next = first_reg;  prev_next = prev_reg;
    stable_next = stable_reg;  byte_next = byte_reg;
    timer_next = poll_reg ? timer_reg + 22'h1 : 22'h0;
    go_next = 1'b0;  req_next = req_reg;
    if (reg_wr && (reg_addr == OFS_ADDR) && !busy_reg) uaddr_next = reg_wdata[ADDR_W-1:0];
    if (reg_wr && (reg_addr == OFS_DATA) && !busy_reg) udata_next = reg_wdata[7:0];
    case (st_reg)
      S_IDLE: begin
        if (reg_wr && (reg_addr == OFS_CTRL)) begin
          op_next = op_t'(reg_wdata[2:0]);
          step_next = 3'd0;  busy_next = 1'b1;  done_next = 1'b0;  tout_next = 1'b0;
          poll_next = 1'b0;
          st_next = (op_t'(reg_wdata[2:0]) == OP_READ) ? S_RD : S_WR;
        end
      end
      S_WR: begin
        go_next  = 1'b1;
        req_next = '{1'b1, sw.addr, sw.data};               // RL9 RL10 RL13 RL21 RL22
        st_next  = S_WR_WAIT;
      end
      S_WR_WAIT: begin
        if (cyc_done) begin
          if (!sw.last) begin
            step_next = step_reg + 3'd1;
            st_next = S_WR;
          end else if ((op_reg == OP_IDENT) || (op_reg == OP_QUERY) || (op_reg == OP_LEAVE)) begin
            busy_next = 1'b0;  done_next = 1'b1;  st_next = S_IDLE;   // RL14
          end else begin
            poll_next = 1'b1;  first_next = 1'b1;  stable_next = 2'd0;
            st_next = S_RD;
          end
        end
      end
      S_RD: begin
        go_next  = 1'b1;
        req_next = '{1'b0, uaddr_reg, 8'h00};
        st_next  = S_RD_WAIT;
      end
      S_RD_WAIT: begin
        if (cyc_done) begin
          byte_next = cyc_byte;
          prev_next = cyc_byte[BUSY_BIT];
          first_next = 1'b0;
          st_next = S_RD;
          if (!poll_reg) begin
            busy_next = 1'b0;  done_next = 1'b1;  st_next = S_IDLE;
          end else if (!first_reg && (cyc_byte[BUSY_BIT] == prev_reg)) begin
            stable_next = stable_reg + 2'd1;                  // RL25
            if (stable_reg == 2'(STABLE_READS - 1)) begin
              busy_next = 1'b0;  done_next = 1'b1;  poll_next = 1'b0;
              st_next = S_IDLE;
            end
          end else begin
            stable_next = 2'd0;                               // RL25
          end
          if (poll_reg && (timer_reg >= limit) && (st_next != S_IDLE)) begin
            busy_next = 1'b0;  done_next = 1'b1;  tout_next = 1'b1;  // RL24
            poll_next = 1'b0;  st_next = S_IDLE;
          end
        end
      end
      default: st_next = S_IDLE;
    endcase
    rdata_next = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:   rdata_next = {29'h0, op_reg};
        OFS_ADDR:   rdata_next = 32'(uaddr_reg);
        OFS_DATA:   rdata_next = {24'h0, udata_reg};
        OFS_STATUS: rdata_next = {16'h0, byte_reg, 5'h0, tout_reg, done_reg, busy_reg};
        default:    rdata_next = 32'h0;
      endcase
    end
  end

  // register the sequencer state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= S_IDLE;  op_reg <= OP_READ;  step_reg <= 3'd0;
      uaddr_reg <= '0;  udata_reg <= 8'h00;
      busy_reg <= 1'b0;  done_reg <= 1'b0;  tout_reg <= 1'b0;
      poll_reg <= 1'b0;  first_reg <= 1'b0;  prev_reg <= 1'b0;
      stable_reg <= 2'd0;  timer_reg <= 22'h0;  byte_reg <= 8'h00;
      go_reg <= 1'b0;  req_reg <= '0;  reg_rdata <= 32'h0;
    end else begin
      st_reg <= st_next;  op_reg <= op_next;  step_reg <= step_next;
      uaddr_reg <= uaddr_next;  udata_reg <= udata_next;
      busy_reg <= busy_next;  done_reg <= done_next;  tout_reg <= tout_next;
      poll_reg <= poll_next;  first_reg <= first_next;  prev_reg <= prev_next;
      stable_reg <= stable_next;  timer_reg <= timer_next;  byte_reg <= byte_next;
      go_reg <= go_next;  req_reg <= req_next;  reg_rdata <= rdata_next;
    end
  end

  // ****************************************************************
  // flash pin cycle engine
  // ****************************************************************
  flash_bus_cycle u_cycle (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .start        (go_reg),
    .req          (req_reg),
    .done         (cyc_done),
    .rd_byte      (cyc_byte),
    .flash_addr   (flash_addr),
    .ce_n         (ce_n),
    .oe_n         (oe_n),
    .we_n         (we_n),
    .byte_bus_out (byte_bus_out),
    .byte_bus_oe  (byte_bus_oe),
    .byte_bus_in  (byte_bus_in)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_unlock_first: assert property (go_reg && req_reg.wr && (step_reg == 3'd0) |->  // RL9
    (req_reg.addr == ADDR_W'(UNLOCK_A1)) && (req_reg.data == UNLOCK_D1))
    else $error("first write is not the unlock word");
  a_unlock_second: assert property (go_reg && req_reg.wr && (step_reg == 3'd1) |->  // RL9
    (req_reg.addr == ADDR_W'(UNLOCK_A2)) && (req_reg.data == UNLOCK_D2))
    else $error("second write is not the unlock word");
  a_prog_length: assert property (cyc_done && (st_reg == S_WR_WAIT) && (op_reg == OP_PROG)  // RL9
    && (step_reg == 3'd3) |=> (st_reg == S_RD) ##1 (st_reg == S_RD_WAIT))
    else $error("program did not end after four writes");
  a_erase_length: assert property ((st_reg == S_WR_WAIT) && (op_reg inside {OP_SECTOR,  // RL10
    OP_BLOCK, OP_CHIP}) && cyc_done && poll_next |-> (step_reg == 3'd5))
    else $error("erase poll began before six writes");
  a_query_code: assert property (go_reg && req_reg.wr && (op_reg == OP_QUERY)  // RL13
    && (step_reg == 3'd2) |-> (req_reg.data == CMD_QUERY)
    && (req_reg.addr == ADDR_W'(UNLOCK_A1)))
    else $error("query entry code wrong");
  a_chip_code: assert property (go_reg && req_reg.wr && (op_reg == OP_CHIP)  // RL22
    && (step_reg == 3'd5) |-> (req_reg.data == CMD_CHIP))
    else $error("chip erase code wrong");
  a_sector_addr: assert property (go_reg && req_reg.wr && (op_reg == OP_SECTOR)  // RL21
    && (step_reg == 3'd5) |-> (req_reg.addr == uaddr_reg) && (req_reg.data == CMD_SECT))
    else $error("sector erase word wrong");
  a_settle_done: assert property ($fell(busy_reg) && $past(poll_reg) && !tout_reg |->  // RL25
    ($past(stable_reg) == 2'(STABLE_READS - 1)))
    else $error("poll finished before the busy bit settled");
  a_no_new_cmd: assert property (busy_reg && reg_wr && (reg_addr == OFS_CTRL) |=>  // RL24
    (op_reg == $past(op_reg)))
    else $error("command accepted while busy");
  a_bus_drive: assert property (byte_bus_oe |-> oe_n)  // RL18
    else $error("data driven while output gate low");

  c_program: cover property ((op_reg == OP_PROG) && $fell(busy_reg));
  c_chip_erase: cover property ((op_reg == OP_CHIP) && $fell(busy_reg));
  c_query: cover property ((op_reg == OP_QUERY) && $fell(busy_reg));
  c_timeout: cover property ($rose(tout_reg));
endmodule : flash_host_ctrl

// ---- flash_model.sv ----
// behavioural parallel flash on the far side of the host controller
// assumes its pins are wired straight to the controller's flash pins
module flash_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER = 8'h3C,  // arbitrary maker code
  parameter logic [7:0] PART  = 8'h7E   // arbitrary part code
) (
  input  wire logic [ADDR_W-1:0] flash_addr,   // address pins
  input  wire logic              ce_n,         // chip select
  input  wire logic              oe_n,         // output gate
  input  wire logic              we_n,         // write strobe
  input  wire logic [7:0]        byte_bus_out, // host data
  input  wire logic              byte_bus_oe,  // host drives data
  output logic      [7:0]        byte_bus_in   // resolved data pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [int];
  time         t_fall = 0;  // time of the last strobe fall, for the glitch floor
  logic [7:0]  drv  = 8'h00;
  logic [7:0]  wb   = 8'h00;
  logic        busy = 1'b0;
  logic        ers  = 1'b0;
  logic        tog  = 1'b0;
  int          step = 0;
  int          mode = 0;
  int          dur  = 0;
  wire  [14:0] lo   = flash_addr[14:0];
  wire  [7:0]  d    = byte_bus_out;
  // host drive wins; a floating bus shows the inverse of the last byte
  assign byte_bus_in = byte_bus_oe ? d : (!ce_n && !oe_n) ? drv : ~drv;
  // remember when the strobe went low so short glitches are refused
  always @(negedge we_n) t_fall = $time;
  // command decode on strobe rise; guard can never be switched off
  always @(posedge we_n) if (!ce_n && oe_n && !busy && ($time - t_fall >= 5)) begin
    if (d == CMD_LEAVE && (step == 0 || step == 2)) begin
      mode = 0;
      step = 0;
    end else case (step)
      0, 4: step = (lo == UNLOCK_A1 && d == UNLOCK_D1) ? step + 1 : 0;
      1, 5: step = (lo == UNLOCK_A2 && d == UNLOCK_D2) ? step + 1 : 0;
      2: begin
        step = lo != UNLOCK_A1 ? 0 : d == CMD_PROG ? 3 : d == CMD_ERASE ? 4 : 0;
        if (lo == UNLOCK_A1 && d == CMD_IDENT) mode = 1;
        if (lo == UNLOCK_A1 && d == CMD_QUERY) mode = 2;
      end
      3: begin
        wb = d;
        mem[flash_addr] = (mem.exists(flash_addr) ? mem[flash_addr] : 8'hFF) & d;
        {ers, dur, step, busy} = {1'b0, 32'd8000, 32'd0, 1'b1};
      end
      default: begin
        foreach (mem[k]) if ((d == CMD_CHIP && lo == UNLOCK_A1) || (d == CMD_SECT
            && k[20:12] == flash_addr[20:12]) || (d == CMD_BLOCK && k[20:16]
            == flash_addr[20:16])) mem[k] = 8'hFF;
        {ers, dur, step, busy} = {1'b1, 32'd50000, 32'd0, 1'b1};
      end
    endcase
  end
  // internal operation ends after its fixed time
  always @(posedge busy) begin
    #(dur) busy = 1'b0;
  end
  // read data chosen as the output gate opens
  always @(negedge oe_n) begin
    #1;
    if (!ce_n) begin
      if (busy) tog = ~tog;
      drv = busy ? {ers ? 1'b0 : ~wb[7], tog, 6'h00} : mode == 1 ? (flash_addr[0] ? PART
          : MAKER) : mode == 2 ? (lo == 15'h0010 ? 8'h51 : 8'h00)
          : mem.exists(flash_addr) ? mem[flash_addr] : 8'hFF;
    end
  end
endmodule : flash_model

// ---- testbench.sv ----
// self-checking bench: register tasks drive the controller against the flash model
// assumes flash_model.sv and the design files are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h3C;  // arbitrary maker code
  localparam logic [7:0] PART  = 8'h7E;  // arbitrary part code
  logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, byte_bus_out, byte_bus_in;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, s;
  logic [ADDR_W-1:0] flash_addr;
  logic ce_n, oe_n, we_n, byte_bus_oe;
  int errors = 0, comparisons = 0;
  flash_host_ctrl #(.ERASE_LIMIT_CYC(2000)) i_flash_host_ctrl (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .byte_bus_out(byte_bus_out), .byte_bus_oe(byte_bus_oe),
    .byte_bus_in(byte_bus_in));
  flash_model #(.MAKER(MAKER), .PART(PART)) i_flash_model (.flash_addr(flash_addr),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .byte_bus_out(byte_bus_out),
    .byte_bus_oe(byte_bus_oe), .byte_bus_in(byte_bus_in));
  // 20 MHz clock
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check
  // one-cycle register strobes, changed just after a rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd_reg
  // start an operation, poll until idle, expect done without timeout
  task automatic do_op(input op_t op, input logic [20:0] a, input logic [7:0] d);
    int n;
    wr_reg(OFS_ADDR, {11'h000, a});
    wr_reg(OFS_DATA, {24'h0, d});
    wr_reg(OFS_CTRL, {29'h0, op});
    s = 32'h1;
    for (n = 0; n < 3000 && s[ST_BUSY] !== 1'b0; n++) rd_reg(OFS_STATUS, s);
    if (s[ST_BUSY] !== 1'b0) begin
      errors++;
      stop_test();
    end
    check("status", 32'h2, {29'h0, s[2:0]});
  endtask : do_op
  task automatic rd_byte(input logic [20:0] a, input logic [7:0] e);
    do_op(OP_READ, a, 8'h00);
    check("byte", {24'h0, e}, {24'h0, s[15:8]});
  endtask : rd_byte
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_reg(OFS_STATUS, s);
    check("reset", 32'h0, s);
    do_op(OP_PROG, 21'h01234, 8'h3C);
    rd_byte(21'h01234, 8'h3C);
    wr_reg(OFS_ADDR, 32'h2000);
    wr_reg(OFS_DATA, 32'h11);
    wr_reg(OFS_CTRL, {29'h0, OP_PROG});
    wr_reg(OFS_CTRL, {29'h0, OP_LEAVE});
    rd_reg(OFS_CTRL, s);
    check("ctrl", {29'h0, OP_PROG}, {29'h0, s[2:0]});
    do_op(OP_READ, 21'h02000, 8'h00);
    do_op(OP_PROG, 21'h10000, 8'h5A);
    do_op(OP_SECTOR, 21'h01000, 8'h00);
    rd_byte(21'h01234, 8'hFF);
    rd_byte(21'h02000, 8'h11);
    do_op(OP_BLOCK, 21'h0F000, 8'h00);
    rd_byte(21'h02000, 8'hFF);
    rd_byte(21'h10000, 8'h5A);
    do_op(OP_CHIP, 21'h00000, 8'h00);
    rd_byte(21'h10000, 8'hFF);
    do_op(OP_IDENT, 21'h0, 8'h0);
    rd_byte(21'h00000, MAKER);
    rd_byte(21'h00001, PART);
    do_op(OP_QUERY, 21'h0, 8'h0);
    rd_byte(21'h00010, 8'h51);
    do_op(OP_LEAVE, 21'h0, 8'h0);
    rd_byte(21'h00010, 8'hFF);
    stop_test();
  end
endmodule : testbench
